// [hdl/ptm_timer.sv]
// periodic timer with period and duty comparators, apb slave
`timescale 1ns/1ns

module ptm_timer
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    input  wire logic        timerIoPinIn,
    input  wire logic        externalClockPinIn,
    output logic             timerIoPinOut,
    output logic             timerIoPinOe,
    // flags
    output logic             matchAFlag,
    output logic             matchPFlag
);

    // ****************************************
    // state
    // ****************************************
    ptm_pkg::ptm_state_type st_r;
    ptm_pkg::ptm_state_type st_nxt;

    logic       wrEn;
    logic       rdEn;
    logic       mapped;
    logic       runRise;
    logic       matchA;
    logic       matchP;
    logic       clrCount;
    logic       capEdge;
    logic       capSrc;
    logic       capSrcDly;
    logic       pwmActive;
    logic       pwmLevel;
    logic [9:0] cntInc;
    logic [1:0] mode;
    logic [1:0] func;

    assign mode    = st_r.ctrl_r.modeSel;
    assign func    = st_r.ctrl_r.outFunc;
    assign mapped  = paddr == ptm_pkg::CTRL_OFFS
                  || paddr == ptm_pkg::PERIOD_OFFS
                  || paddr == ptm_pkg::DUTY_OFFS
                  || paddr == ptm_pkg::STAT_OFFS
                  || paddr == ptm_pkg::COUNT_OFFS;
    assign wrEn    = psel && penable && pwrite && mapped;
    assign rdEn    = psel && !penable && !pwrite;
    assign runRise = st_r.ctrl_r.runBit && !st_r.runDly_r;
    assign cntInc  = 10'(st_r.count_r + 10'h001);

    // ****************************************
    // comparators
    // ****************************************
    // equality compare
    always_comb
    begin
        matchA = st_r.ctrl_r.runBit && !runRise
              && st_r.count_r == st_r.duty_r;
        if (st_r.period_r == ptm_pkg::CMP_RST)
            matchP = st_r.ctrl_r.runBit && !runRise
                  && st_r.count_r == 10'h3FF;
        else
            matchP = st_r.ctrl_r.runBit && !runRise
                  && cntInc == st_r.period_r;
    end

    // ****************************************
    // capture edge select
    // ****************************************
    // capture pin choice
    assign capSrc    = st_r.ctrl_r.captureSourceSelect
                     ? st_r.pinsDly_r.externalClockPin
                     : st_r.pinsDly_r.timerIoPin;
    assign capSrcDly = st_r.ctrl_r.captureSourceSelect
                     ? externalClockPinIn : timerIoPinIn;

    always_comb
    begin
        case (func)
            2'b00:   capEdge = capSrcDly && !capSrc;
            2'b01:   capEdge = !capSrcDly && capSrc;
            2'b10:   capEdge = capSrcDly != capSrc;
            default: capEdge = 1'b0;
        endcase
    end

    always_comb
    begin
        if (st_r.period_r != ptm_pkg::CMP_RST
            && st_r.duty_r >= st_r.period_r)
            pwmActive = 1'b1;
        else
            pwmActive = st_r.count_r < st_r.duty_r;
    end

    assign pwmLevel = (pwmActive && st_r.ctrl_r.runBit)
                    ^ !st_r.ctrl_r.outputLevelCtrl
                    ^ st_r.ctrl_r.outputInvert;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.runDly_r  = st_r.ctrl_r.runBit;
        st_nxt.pinsDly_r = '{timerIoPinIn, externalClockPinIn};
        clrCount = 1'b0;

        // status clears come first so a same-cycle set wins
        if (wrEn && paddr == ptm_pkg::STAT_OFFS)
        begin
            if (pwdata[ptm_pkg::STAT_AFLG_POS])
                st_nxt.aFlag_r = 1'b0;
            if (pwdata[ptm_pkg::STAT_PFLG_POS])
                st_nxt.pFlag_r = 1'b0;
        end

        // counter and flags per mode
        // mode decode
        case (mode)
            ptm_pkg::MODE_CMP, ptm_pkg::MODE_TC:
            begin
                if (!st_r.ctrl_r.clearSelect && matchP)
                    clrCount = 1'b1;
                if (st_r.ctrl_r.clearSelect && matchA)
                    clrCount = 1'b1;
                if (matchA)
                    st_nxt.aFlag_r = 1'b1;
                if (matchP && !st_r.ctrl_r.clearSelect)
                    st_nxt.pFlag_r = 1'b1;
                if (matchA && mode == ptm_pkg::MODE_CMP)
                begin
                    case (func)
                        ptm_pkg::FUNC_LOW:  st_nxt.pin_r = 1'b0;
                        ptm_pkg::FUNC_HIGH: st_nxt.pin_r = 1'b1;
                        ptm_pkg::FUNC_TOG:  st_nxt.pin_r = !st_r.pin_r;
                        default:            st_nxt.pin_r = st_r.pin_r;
                    endcase
                end
            end
            ptm_pkg::MODE_PWM:
            begin
                if (func == ptm_pkg::FUNC_TOG)
                begin
                    if (matchA)
                    begin
                        st_nxt.aFlag_r = 1'b1;
                        st_nxt.ctrl_r.runBit = 1'b0;
                    end
                end
                else
                begin
                    if (matchP)
                    begin
                        clrCount = 1'b1;
                        st_nxt.pFlag_r = 1'b1;
                    end
                    if (matchA)
                        st_nxt.aFlag_r = 1'b1;
                end
            end
            default:
            begin
                if (matchP)
                begin
                    clrCount = 1'b1;
                    st_nxt.pFlag_r = 1'b1;
                end
                if (capEdge && st_r.ctrl_r.runBit)
                begin
                    st_nxt.duty_r  = st_r.count_r;
                    st_nxt.aFlag_r = 1'b1;
                end
            end
        endcase

        if (runRise)
            st_nxt.count_r = 10'h000;
        else if (!st_r.ctrl_r.runBit)
            st_nxt.count_r = st_r.count_r;
        else if (clrCount)
            st_nxt.count_r = 10'h000;
        else
            st_nxt.count_r = cntInc;

        if (runRise)
            st_nxt.pin_r = st_r.ctrl_r.outputLevelCtrl;

        if (mode == ptm_pkg::MODE_PWM && func == ptm_pkg::FUNC_TOG
            && externalClockPinIn && !st_r.pinsDly_r.externalClockPin)
            st_nxt.ctrl_r.runBit = 1'b1;

        // register writes
        if (wrEn)
        begin
            case (paddr)
                ptm_pkg::CTRL_OFFS:
                    st_nxt.ctrl_r = pwdata[8:0];
                ptm_pkg::PERIOD_OFFS:
                    st_nxt.period_r = pwdata[9:0];
                ptm_pkg::DUTY_OFFS:
                    st_nxt.duty_r = pwdata[9:0];
                default:
                    st_nxt.period_r = st_r.period_r;
            endcase
        end

        // read data captured in setup phase
        st_nxt.rdata_r = ptm_pkg::RDZERO;
        if (rdEn)
        begin
            case (paddr)
                ptm_pkg::CTRL_OFFS:   st_nxt.rdata_r[8:0] = st_r.ctrl_r;
                ptm_pkg::PERIOD_OFFS: st_nxt.rdata_r[9:0] = st_r.period_r;
                ptm_pkg::DUTY_OFFS:   st_nxt.rdata_r[9:0] = st_r.duty_r;
                ptm_pkg::COUNT_OFFS:  st_nxt.rdata_r[9:0] = st_r.count_r;
                ptm_pkg::STAT_OFFS:
                    st_nxt.rdata_r[2:0] = {st_r.pin_r, st_r.pFlag_r,
                                           st_r.aFlag_r};
                default:              st_nxt.rdata_r = ptm_pkg::RDZERO;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata     = st_r.rdata_r;
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && !mapped;
    assign matchAFlag = st_r.aFlag_r;
    assign matchPFlag = st_r.pFlag_r;

    always_comb
    begin
        timerIoPinOe  = 1'b1;
        timerIoPinOut = 1'b0;
        case (mode)
            ptm_pkg::MODE_CMP:
            begin
                timerIoPinOe  = 1'b0;
                timerIoPinOut = st_r.pin_r ^ st_r.ctrl_r.outputInvert;
            end
            ptm_pkg::MODE_PWM:
            begin
                timerIoPinOe = 1'b0;
                case (func)
                    ptm_pkg::FUNC_NONE: timerIoPinOut =
                        st_r.ctrl_r.outputInvert;
                    ptm_pkg::FUNC_LOW:  timerIoPinOut =
                        !st_r.ctrl_r.outputInvert;
                    default:            timerIoPinOut = pwmLevel;
                endcase
            end
            default:
            begin
                timerIoPinOe  = 1'b1;
                timerIoPinOut = 1'b0;
            end
        endcase
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    runRiseZero_a: assert property (runRise |=>
        st_r.count_r == 10'h000)
        else $error("counter not zero after run rise");
    initLevel_a: assert property (runRise |=>
        st_r.pin_r == $past(st_r.ctrl_r.outputLevelCtrl))
        else $error("initial level wrong");
    noPFlag_a: assert property ((mode == ptm_pkg::MODE_CMP
        && st_r.ctrl_r.clearSelect && !wrEn && !st_r.pFlag_r)
        |=> !st_r.pFlag_r)
        else $error("period flag raised with duty clear");
    tcPinFree_a: assert property (mode == ptm_pkg::MODE_TC
        |-> timerIoPinOe)
        else $error("pin driven in timer mode");
    pClear_a: assert property ((mode == ptm_pkg::MODE_CMP
        && !st_r.ctrl_r.clearSelect && matchP && !wrEn)
        |=> st_r.count_r == 10'h000 && st_r.pFlag_r)
        else $error("period match did not clear");
    pulseEnd_a: assert property ((mode == ptm_pkg::MODE_PWM
        && func == ptm_pkg::FUNC_TOG && matchA && !wrEn)
        |=> !st_r.ctrl_r.runBit)
        else $error("pulse not ended");
    capLatch_a: assert property ((mode == ptm_pkg::MODE_CAP
        && capEdge && st_r.ctrl_r.runBit && !wrEn)
        |=> st_r.duty_r == $past(st_r.count_r))
        else $error("capture not latched");
    aSticky_a: assert property ((st_r.aFlag_r && !wrEn)
        |=> st_r.aFlag_r)
        else $error("duty flag lost");

    pwmRun_c:  cover property (mode == ptm_pkg::MODE_PWM && matchP);
    pulse_c:   cover property (mode == ptm_pkg::MODE_PWM && matchA
                               && func == ptm_pkg::FUNC_TOG);
    capture_c: cover property (mode == ptm_pkg::MODE_CAP && capEdge);

endmodule

// [hdl/ptm_pkg.sv]
// package: constants, register map and carrier types of the periodic timer
package ptm_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [11:0] CTRL_OFFS   = 12'h000;
    localparam logic [11:0] PERIOD_OFFS = 12'h004;
    localparam logic [11:0] DUTY_OFFS   = 12'h008;
    localparam logic [11:0] STAT_OFFS   = 12'h00C;
    localparam logic [11:0] COUNT_OFFS  = 12'h010;

    // ****************************************
    // control and status field positions
    // ****************************************
    localparam int CTRL_RUN_POS   = 0;
    localparam int CTRL_CCLR_POS  = 1;
    localparam int CTRL_CAPS_POS  = 2;
    localparam int CTRL_INV_POS   = 3;
    localparam int CTRL_OLVL_POS  = 4;
    localparam int CTRL_FUNC_POS  = 5;
    localparam int CTRL_MODE_POS  = 7;
    localparam int STAT_AFLG_POS  = 0;
    localparam int STAT_PFLG_POS  = 1;
    localparam int STAT_PIN_POS   = 2;

    // ****************************************
    // reset values and widths
    // ****************************************
    localparam int          CNT_W       = 10;
    localparam logic [8:0]  CTRL_RST    = 9'h000;
    localparam logic [9:0]  CMP_RST     = 10'h000;
    localparam logic [31:0] RDZERO      = 32'h0000_0000;

    // mode field values
    localparam logic [1:0] MODE_CMP = 2'b00;
    localparam logic [1:0] MODE_CAP = 2'b01;
    localparam logic [1:0] MODE_PWM = 2'b10;
    localparam logic [1:0] MODE_TC  = 2'b11;

    // output function values
    localparam logic [1:0] FUNC_NONE = 2'b00;
    localparam logic [1:0] FUNC_LOW  = 2'b01;
    localparam logic [1:0] FUNC_HIGH = 2'b10;
    localparam logic [1:0] FUNC_TOG  = 2'b11;

    typedef struct packed {
        logic [1:0] modeSel;
        logic [1:0] outFunc;
        logic       outputLevelCtrl;
        logic       outputInvert;
        logic       captureSourceSelect;
        logic       clearSelect;
        logic       runBit;
    } ptm_ctrl_type;

    typedef struct packed {
        logic       timerIoPin;
        logic       externalClockPin;
    } ptm_pins_type;

    typedef struct packed {
        ptm_ctrl_type     ctrl_r;
        logic [9:0]       period_r;
        logic [9:0]       duty_r;
        logic [9:0]       count_r;
        logic             aFlag_r;
        logic             pFlag_r;
        logic             pin_r;
        logic             runDly_r;
        ptm_pins_type     pinsDly_r;
        logic [31:0]      rdata_r;
    } ptm_state_type;

endpackage

// [test/ptm_pin_model.sv]
// behavioural driver of the external capture and trigger pins
`timescale 1ns/1ns
module ptm_pin_model
(
    // clock
    input  wire logic       clk,
    // one-cycle pulse requests: bit 0 timer pin, bit 1 clock pin
    input  wire logic [1:0] pulseReq,
    // pin levels
    output logic            timerPin,
    output logic            extPin
);
    logic [2:0] tmrCnt = 3'h0;
    logic [2:0] extCnt = 3'h0;

    // each pulse stays high four cycles so both edges reach the block
    always_ff @(posedge clk)
    begin
        tmrCnt <= pulseReq[0] ? 3'h4 : tmrCnt - 3'(tmrCnt != 3'h0);
        extCnt <= pulseReq[1] ? 3'h4 : extCnt - 3'(extCnt != 3'h0);
    end
    assign timerPin = (tmrCnt != 3'h0);
    assign extPin   = (extCnt != 3'h0);
endmodule

// [test/tb_top.sv]
// self-checking bench of the periodic timer
`timescale 1ns/1ns
module tb_top;
    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pinOut;
    logic        pinOe;
    logic        pinW;
    logic        mdlTimer;
    logic        mdlExt;
    logic        aFlag;
    logic        pFlag;
    logic [1:0]  pulseReq;
    logic [31:0] rdVal;
    logic        rdErr;
    logic [15:0] seed = 16'hBE02;
    int          failures = 0;
    int          samples_checked = 0;

    // design drives the pin while its enable is low
    assign pinW = pinOe ? mdlTimer : pinOut;

    ptm_timer u_ptm_timer (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timerIoPinIn(pinW), .externalClockPinIn(mdlExt),
        .timerIoPinOut(pinOut), .timerIoPinOe(pinOe),
        .matchAFlag(aFlag), .matchPFlag(pFlag));
    ptm_pin_model u_ptm_pin_model (.clk(clk), .pulseReq(pulseReq),
        .timerPin(mdlTimer), .extPin(mdlExt));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // fields: mode, function, level, invert, source, clear select, run
    function automatic logic [31:0] ctl(input logic [1:0] m,
        input logic [1:0] f, input logic ol, input logic iv,
        input logic cs, input logic cc, input logic r);
        return {23'h0, m, f, ol, iv, cs, cc, r};
    endfunction

    task automatic print_verdict();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rdVal = prdata;
        rdErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // stop, load comparators, clear flags, then start with c
    task automatic cfg(input logic [9:0] p, input logic [9:0] d,
        input logic [31:0] c);
        wr(ptm_pkg::CTRL_OFFS, c & 32'hFFFF_FFFE);
        wr(ptm_pkg::PERIOD_OFFS, {22'h0, p});
        wr(ptm_pkg::DUTY_OFFS, {22'h0, d});
        wr(ptm_pkg::STAT_OFFS, 32'h0000_0003);
        wr(ptm_pkg::CTRL_OFFS, c);
    endtask

    task automatic hcount(input int n, output int h);
        h = 0;
        repeat (n)
        begin
            @(posedge clk);
            h += int'(pinW === 1'b1);
        end
    endtask

    task automatic pulse(input int i);
        pulseReq[i] <= 1'b1;
        @(posedge clk);
        pulseReq    <= 2'b00;
        idle(8);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        #200000;
        failures++;
        print_verdict();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        logic [1:0]  fn [3];
        logic        ol [3];
        logic [11:0] offs [5];
        int          p;
        int          d;
        int          h;
        int          act;
        logic        o;
        logic        iv;
        fn = '{ptm_pkg::FUNC_HIGH, ptm_pkg::FUNC_LOW, ptm_pkg::FUNC_NONE};
        ol = '{1'b0, 1'b1, 1'b1};
        offs = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pulseReq = 2'b00;
        idle(6);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (offs[i])
        begin
            rd(offs[i]);
            check("reset value", 32'h0000_0000, rdVal);
        end
        rd(12'h0FC);
        check("unmapped error", 32'h1, {31'h0, rdErr});
        check("unmapped data", 32'h0, rdVal);
        // software keeps duty nonzero in compare mode
        for (int i = 0; i < 3; i++)
        begin
            cfg(10'h00C, 10'h005, ctl(2'b00, fn[i], ol[i], 0, 0, 0, 1));
            idle(2);
            check("initial pin", {31'h0, ol[i]}, {31'h0, pinW});
            idle(30);
            check("match pin", {31'h0, i != 1}, {31'h0, pinW});
        end
        cfg(10'h008, 10'h002, ctl(2'b00, 2'b11, 0, 0, 0, 0, 1));
        idle(16);
        hcount(64, h);
        check("toggle high", 32'd32, 32'(h));
        cfg(10'h004, 10'h002, ctl(2'b00, 2'b10, 0, 0, 0, 0, 1));
        idle(20);
        rd(ptm_pkg::STAT_OFFS);
        check("period flags", 32'h3, rdVal & 32'h3);
        check("flag pins", 32'h3, {30'h0, pFlag, aFlag});
        rd(ptm_pkg::COUNT_OFFS);
        check("count range", 32'h1, {31'h0, rdVal < 4});
        cfg(10'h003, 10'h007, ctl(2'b00, 2'b10, 0, 0, 0, 1, 1));
        idle(30);
        rd(ptm_pkg::STAT_OFFS);
        check("duty clear flags", 32'h1, rdVal & 32'h3);
        check("duty flag pins", 32'h1, {30'h0, pFlag, aFlag});
        cfg(10'h000, 10'h002, ctl(2'b11, 2'b10, 0, 1, 0, 0, 1));
        idle(1100);
        check("timer released", 32'h1, {31'h0, pinOe});
        rd(ptm_pkg::STAT_OFFS);
        check("overflow flags", 32'h3, rdVal & 32'h3);
        // pwm needs mode 10 and function 10
        for (int i = 0; i < 5; i++)
        begin
            seed = lfsr(seed);
            p = 4 + int'(seed[5:0]);
            seed = lfsr(seed);
            d = int'(seed[6:0]) % (p + 4);
            o = seed[7];
            iv = seed[8];
            if (i == 4)
            begin
                p = 1024;
                d = 300;
            end
            cfg(10'(p), 10'(d), ctl(2'b10, 2'b10, o, iv, 0, seed[9], 1));
            idle(2 * p);
            hcount(4 * p, h);
            act = (d >= p) ? p : d;
            h = (o ^ iv) ? h : 4 * p - h;
            check("pwm active", 32'(4 * act), 32'(h));
            rd(ptm_pkg::STAT_OFFS);
            check("pwm p flag", 32'h1, {31'h0, rdVal[1]});
        end
        cfg(10'h00A, 10'h004, ctl(2'b10, 2'b01, 1, 0, 0, 0, 1));
        hcount(50, h);
        check("forced pin", 32'h1, {31'h0, h == 0 || h == 50});
        rd(ptm_pkg::COUNT_OFFS);
        p = int'(rdVal);
        rd(ptm_pkg::COUNT_OFFS);
        check("count runs", 32'h1, {31'h0, p != int'(rdVal)});
        // single pulse keeps function 11 throughout
        for (int i = 0; i < 2; i++)
        begin
            cfg(10'h000, 10'h014, ctl(2'b10, 2'b11, 1, 0, 0, 0, i == 0));
            if (i == 1)
                pulse(1);
            hcount(60, h);
            check("pulse width", 32'h1, {31'h0, h >= 11 && h <= 23});
            rd(ptm_pkg::CTRL_OFFS);
            check("run cleared", 32'h0, {31'h0, rdVal[0]});
            rd(ptm_pkg::STAT_OFFS);
            check("pulse flag", 32'h1, rdVal & 32'h1);
        end
        cfg(10'h000, 10'h0C8, ctl(2'b10, 2'b11, 1, 0, 0, 0, 1));
        idle(10);
        wr(ptm_pkg::CTRL_OFFS, ctl(2'b10, 2'b11, 1, 0, 0, 0, 0));
        check("soft end", 32'h0, {31'h0, pinW});
        rd(ptm_pkg::COUNT_OFFS);
        p = int'(rdVal);
        idle(5);
        rd(ptm_pkg::COUNT_OFFS);
        check("count held", 32'h1, {31'h0, p == int'(rdVal) && p != 0});
        cfg(10'h000, 10'h155, ctl(2'b01, 2'b11, 0, 0, 0, 0, 1));
        pulse(0);
        rd(ptm_pkg::DUTY_OFFS);
        check("no capture", 32'h155, rdVal);
        for (int i = 0; i < 4; i++)
        begin
            cfg(10'h000, 10'h155, ctl(2'b01, 2'(i % 3), 0, 0, i == 3, 0, 1));
            idle(30);
            pulse(0);
            rd(ptm_pkg::STAT_OFFS);
            check("capture flag", {31'h0, i != 3}, rdVal & 32'h1);
            if (i == 3)
                pulse(1);
            rd(ptm_pkg::DUTY_OFFS);
            check("captured", 32'h1, {31'h0, rdVal > 20 && rdVal < 80});
        end
        cfg(10'h010, 10'h3FF, ctl(2'b01, 2'b11, 0, 0, 0, 0, 1));
        idle(40);
        rd(ptm_pkg::STAT_OFFS);
        check("capture p flag", 32'h2, rdVal & 32'h3);
        print_verdict();
    end
endmodule
